// ### hw/bade_defines.svh
// constants for the decimal adjust and file decrement execution block
// Contract
// - low nibble above nine or nibble carry: add six
// - high nibble takes the low carry, then above nine or carry: add six
// - adjust is word 0007h, one cycle, carry only
// - decrement 0000 01da ffff ffff updates five flags
// - destination bit 0 to working, 1 to file
// - bank bit 0 access bank, 1 bank select
// - access, extended set, address to 5Fh: indexed offset
`ifndef BADE_DEFINES_SVH
`define BADE_DEFINES_SVH
`define BADE_ADJ_WORD 16'h0007
`define BADE_DEC_OPC 6'h01
`define BADE_OPC_HI 15
`define BADE_OPC_LO 10
`define BADE_DEST_BIT 9
`define BADE_ACC_BIT 8
`define BADE_BCD_MAX 4'h9
`define BADE_BCD_ADJ 4'h6
`define BADE_ILO_MAX 8'h5f
`define BADE_ACCESS_SPLIT 8'h60
`define BADE_ACCESS_LO_BANK 4'h0
`define BADE_ACCESS_HI_BANK 4'hf
`define BADE_W_RESET 8'h00
`define BADE_STATUS_RESET 5'h00
`endif

// ### hw/bade_pkg.sv
// types shared by the execution block
package bade_pkg;
  typedef struct packed {
    logic n;
    logic signed_wrap_flag;
    logic z;
    logic nibble_carry_flag;
    logic c;
  } bade_status_t;

  typedef struct packed {
    logic [7:0] w_reg;
    bade_status_t status;
    logic file_we;
    logic [11:0] file_waddr;
    logic [7:0] file_wdata;
    logic done;
  } bade_state_t;
endpackage

// ### hw/bade_addr_gen.sv
// operand address forming for file operand instructions
`timescale 1ns/1ns
`include "bade_defines.svh"
module bade_addr_gen
  import bade_pkg::*;
#(
  parameter int BANK_W = 4
) (
  input wire logic [7:0] f_addr,
  input wire logic acc_sel,
  input wire logic ext_set_en,
  input wire logic [BANK_W-1:0] bank_select_reg,
  input wire logic [BANK_W+7:0] fsr2_base,
  output logic [BANK_W+7:0] file_addr,
  output logic indexed
);
  always_comb begin
    indexed = !acc_sel && ext_set_en && (f_addr <= `BADE_ILO_MAX);
    if (indexed) begin
      // literal offset from the frame pointer; wraps within the data space
      file_addr = (BANK_W+8)'(fsr2_base + {{BANK_W{1'b0}}, f_addr});
    end else if (acc_sel) begin
      file_addr = {bank_select_reg, f_addr};
    end else if (f_addr < `BADE_ACCESS_SPLIT) begin
      file_addr = {(BANK_W)'(`BADE_ACCESS_LO_BANK), f_addr};
    end else begin
      file_addr = {(BANK_W)'(`BADE_ACCESS_HI_BANK), f_addr};
    end
  end
endmodule

// ### hw/bade_exec.sv
// decimal adjust and file decrement execution stage with working register
`timescale 1ns/1ns
`include "bade_defines.svh"
module bade_exec
  import bade_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic ext_set_en,
  input wire logic [3:0] bank_select_reg,
  input wire logic [11:0] fsr2_base,
  output logic [11:0] file_addr,
  input wire logic [7:0] file_rdata,
  input wire logic load_en,
  input wire logic [7:0] load_w,
  input wire logic [4:0] load_status,
  output logic [7:0] w_out,
  output bade_status_t status_out,
  output logic file_we,
  output logic [11:0] file_waddr,
  output logic [7:0] file_wdata,
  output logic exec_done,
  output logic indexed_mode
);
  function automatic logic is_adj_op(input logic [15:0] word);
    return word == `BADE_ADJ_WORD;
  endfunction

  function automatic logic is_dec_op(input logic [15:0] word);
    return word[`BADE_OPC_HI:`BADE_OPC_LO] == `BADE_DEC_OPC;
  endfunction

  bade_state_t state_reg;
  bade_state_t state_next;
  logic [3:0] lo_nib;
  logic [3:0] hi_nib;
  logic [4:0] lo_sum;
  logic lo_carry;
  logic [4:0] hi_base;
  logic [4:0] hi_sum;
  logic [7:0] dec_res;

  bade_addr_gen #(
    .BANK_W(4)
  ) u_addr (
    .f_addr(instr[7:0]),
    .acc_sel(instr[`BADE_ACC_BIT]),
    .ext_set_en(ext_set_en),
    .bank_select_reg(bank_select_reg),
    .fsr2_base(fsr2_base),
    .file_addr(file_addr),
    .indexed(indexed_mode)
  );

  always_comb begin
    state_next = state_reg;
    state_next.file_we = 1'b0;
    state_next.done = 1'b0;
    lo_nib = state_reg.w_reg[3:0];
    hi_nib = state_reg.w_reg[7:4];
    lo_sum = {1'b0, lo_nib};
    if (lo_nib > `BADE_BCD_MAX || state_reg.status.nibble_carry_flag) begin
      lo_sum = {1'b0, lo_nib} + {1'b0, `BADE_BCD_ADJ};
    end
    // the carry out of the low correction is the nibble carry into the high nibble
    lo_carry = lo_sum[4];
    hi_base = {1'b0, hi_nib} + {4'h0, lo_carry};
    hi_sum = hi_base;
    if (hi_base > {1'b0, `BADE_BCD_MAX} || state_reg.status.c) begin
      hi_sum = hi_base + {1'b0, `BADE_BCD_ADJ};
    end
    dec_res = file_rdata - 8'h01;
    // a direct load wins over execution so the core can seed w and flags
    if (load_en) begin
      state_next.w_reg = load_w;
      state_next.status = load_status;
    end else if (instr_valid && is_adj_op(instr)) begin
      state_next.w_reg = {hi_sum[3:0], lo_sum[3:0]};
      state_next.status.c = hi_sum[4] | state_reg.status.c;
      state_next.done = 1'b1;
    end else if (instr_valid && is_dec_op(instr)) begin
      state_next.status.c = file_rdata != 8'h00;
      // a borrow out of the low nibble only happens when it was zero
      state_next.status.nibble_carry_flag = file_rdata[3:0] != 4'h0;
      state_next.status.n = dec_res[7];
      state_next.status.signed_wrap_flag = file_rdata == 8'h80;
      state_next.status.z = dec_res == 8'h00;
      state_next.done = 1'b1;
      if (instr[`BADE_DEST_BIT]) begin
        state_next.file_we = 1'b1;
        state_next.file_waddr = file_addr;
        state_next.file_wdata = dec_res;
      end else begin
        state_next.w_reg = dec_res;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
      state_reg.w_reg <= `BADE_W_RESET;
      state_reg.status <= `BADE_STATUS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign w_out = state_reg.w_reg;
  assign status_out = state_reg.status;
  assign file_we = state_reg.file_we;
  assign file_waddr = state_reg.file_waddr;
  assign file_wdata = state_reg.file_wdata;
  assign exec_done = state_reg.done;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_adj_issue;
    instr_valid && !load_en && is_adj_op(instr);
  endsequence

  sequence s_dec_issue;
    instr_valid && !load_en && is_dec_op(instr);
  endsequence

  property p_adj_low_fix;
    s_adj_issue ##0 (state_reg.w_reg[3:0] > 4'h9 || state_reg.status.nibble_carry_flag) |=>
      w_out[3:0] == 4'($past(state_reg.w_reg[3:0]) + 4'h6);
  endproperty
  a_adj_low_fix: assert property (p_adj_low_fix) else $error("low nibble not corrected");

  property p_adj_low_keep;
    s_adj_issue ##0 (state_reg.w_reg[3:0] <= 4'h9 && !state_reg.status.nibble_carry_flag) |=>
      w_out[3:0] == $past(state_reg.w_reg[3:0]);
  endproperty
  a_adj_low_keep: assert property (p_adj_low_keep) else $error("low nibble changed");

  property p_adj_high_c;
    s_adj_issue ##0 (state_reg.status.c && state_reg.w_reg[3:0] <= 4'h9 &&
      !state_reg.status.nibble_carry_flag)
      |=> w_out[7:4] == 4'($past(state_reg.w_reg[7:4]) + 4'h6) && status_out.c;
  endproperty
  a_adj_high_c: assert property (p_adj_high_c) else $error("high nibble not corrected");

  // no low correction, no carry and a decimal high digit: high nibble kept
  property p_adj_high_keep;
    s_adj_issue ##0 (!state_reg.status.c && state_reg.w_reg[3:0] <= 4'h9 &&
      !state_reg.status.nibble_carry_flag && state_reg.w_reg[7:4] <= 4'h9)
      |=> w_out[7:4] == $past(state_reg.w_reg[7:4]) && !status_out.c;
  endproperty
  a_adj_high_keep: assert property (p_adj_high_keep) else $error("high nibble changed");

  property p_adj_flags;
    s_adj_issue |=> $stable(status_out.nibble_carry_flag) && $stable(status_out.z) &&
      $stable(status_out.n) && $stable(status_out.signed_wrap_flag) && exec_done && !file_we;
  endproperty
  a_adj_flags: assert property (p_adj_flags) else $error("adjust touched other flags");

  property p_done_cause;
    exec_done |-> $past(instr_valid && !load_en && (is_adj_op(instr) || is_dec_op(instr)));
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("completion without an op");

  property p_dec_to_w;
    s_dec_issue ##0 !instr[9] |=> w_out == 8'($past(file_rdata) - 8'h01) && !file_we;
  endproperty
  a_dec_to_w: assert property (p_dec_to_w) else $error("decrement to w wrong");

  property p_dec_to_f;
    s_dec_issue ##0 instr[9] |=> file_we && $stable(w_out) &&
      file_waddr == $past(file_addr) && file_wdata == 8'($past(file_rdata) - 8'h01);
  endproperty
  a_dec_to_f: assert property (p_dec_to_f) else $error("decrement write back wrong");

  property p_we_cause;
    file_we |-> $past(instr_valid && !load_en && is_dec_op(instr) && instr[9]);
  endproperty
  a_we_cause: assert property (p_we_cause) else $error("file write without decrement");

  property p_dec_flags;
    s_dec_issue |=> status_out.z == ($past(file_rdata) == 8'h01) &&
      status_out.signed_wrap_flag == ($past(file_rdata) == 8'h80) && exec_done;
  endproperty
  a_dec_flags: assert property (p_dec_flags) else $error("decrement flags wrong");

  property p_dec_sign;
    s_dec_issue |=> status_out.n == ($past(file_rdata) > 8'h80 || $past(file_rdata) == 8'h00);
  endproperty
  a_dec_sign: assert property (p_dec_sign) else $error("decrement sign wrong");

  property p_dec_nib;
    s_dec_issue |=> status_out.nibble_carry_flag == ($past(file_rdata[3:0]) != 4'h0);
  endproperty
  a_dec_nib: assert property (p_dec_nib) else $error("decrement nibble borrow wrong");

  property p_dec_carry;
    s_dec_issue |=> status_out.c == ($past(file_rdata) != 8'h00);
  endproperty
  a_dec_carry: assert property (p_dec_carry) else $error("borrow sense wrong");

  property p_bank_sel;
    instr_valid && is_dec_op(instr) && instr[8] |-> file_addr == {bank_select_reg, instr[7:0]};
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("bank select address wrong");

  property p_indexed;
    instr_valid && !instr[8] && ext_set_en && instr[7:0] <= 8'h5f |->
      indexed_mode && file_addr == 12'(fsr2_base + {4'h0, instr[7:0]});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed offset address wrong");

  // access bank splits low page to bank zero and the rest to the top bank
  property p_access_bank;
    instr_valid && !instr[8] && !(ext_set_en && instr[7:0] <= 8'h5f) |-> !indexed_mode &&
      file_addr == {(instr[7:0] < 8'h60) ? 4'h0 : 4'hf, instr[7:0]};
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank address wrong");
endmodule

// ### bench/tb_bade_exec.sv
// self-checking bench for the adjust and decrement execution stage
`timescale 1ns/1ns
module tb_bade_exec;
  import bade_pkg::*;
  typedef struct packed {
    logic [15:0] op;
    logic ext;
    logic [7:0] val;
  } bade_row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic ext_set_en = 1'b0;
  logic [3:0] bank_select_reg = 4'h5;
  logic [11:0] fsr2_base = 12'h3f0;
  logic [7:0] file_rdata = 8'h00;
  logic load_en = 1'b0;
  logic [7:0] load_w = 8'h00;
  logic [4:0] load_status = 5'h00;
  logic [11:0] file_addr, file_waddr;
  logic [7:0] w_out, file_wdata;
  bade_status_t status_out;
  logic file_we, exec_done, indexed_mode;
  int err_count = 0;
  int checked = 0;
  bade_row_t rows [7] = '{'{16'h0703, 1'b0, 8'h01}, '{16'h0680, 1'b0, 8'h00},
    '{16'h0410, 1'b1, 8'h80}, '{16'h045f, 1'b1, 8'h10}, '{16'h0460, 1'b1, 8'h5a},
    '{16'h055f, 1'b1, 8'h33}, '{16'h045f, 1'b0, 8'h21}};
  // w, nibble carry, carry before the adjust
  logic [9:0] adj_rows [7] = '{{8'ha5, 2'b00}, {8'hce, 2'b00}, {8'h99, 2'b10},
    {8'h3a, 2'b01}, {8'h19, 2'b11}, {8'h00, 2'b00}, {8'h9a, 2'b00}};

  bade_exec bade_exec_i (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr(instr), .ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg),
    .fsr2_base(fsr2_base), .file_addr(file_addr), .file_rdata(file_rdata),
    .load_en(load_en), .load_w(load_w), .load_status(load_status), .w_out(w_out),
    .status_out(status_out), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .exec_done(exec_done), .indexed_mode(indexed_mode));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic load(input logic [7:0] w, input logic [4:0] st);
    @(negedge clk);
    load_en = 1'b1;
    load_w = w;
    load_status = st;
    @(negedge clk);
    load_en = 1'b0;
  endtask

  // memory data is inverted once released so a late read cannot look right
  task automatic run(input logic [15:0] op, input logic [7:0] rd);
    @(negedge clk);
    instr_valid = 1'b1;
    instr = op;
    file_rdata = rd;
    @(negedge clk);
    instr_valid = 1'b0;
    file_rdata = ~rd;
  endtask

  function automatic logic [11:0] ea(input logic [15:0] op, input logic ext);
    if (op[8]) return {bank_select_reg, op[7:0]};
    if (ext && op[7:0] <= 8'h5f) return fsr2_base + {4'h0, op[7:0]};
    return {(op[7:0] < 8'h60) ? 4'h0 : 4'hf, op[7:0]};
  endfunction

  // carry into the high nibble is the carry out of the low correction
  function automatic logic [8:0] adj(input logic [7:0] w, input logic ncy, input logic cy);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, w[3:0]} + ((w[3:0] > 4'h9 || ncy) ? 5'h06 : 5'h00);
    hi = {1'b0, w[7:4]} + {4'h0, lo[4]};
    if (hi > 5'h09 || cy) hi = hi + 5'h06;
    return {hi[4] | cy, hi[3:0], lo[3:0]};
  endfunction

  initial begin
    #20000;
    err_count++;
    end_of_test();
  end

  initial begin
    bade_row_t r;
    logic [7:0] d;
    logic [7:0] w_e;
    bade_status_t st_e;
    logic [9:0] a;
    logic [8:0] x;
    repeat (20) @(negedge clk);
    chk("w_rst", w_out, 16'h0000);
    chk("st_rst", status_out, 16'h0000);
    chk("done_rst", exec_done, 16'h0000);
    arst_n = 1'b1;
    w_e = 8'h5a;
    load(w_e, 5'h00);
    foreach (rows[i]) begin
      r = rows[i];
      @(negedge clk);
      instr = r.op;
      ext_set_en = r.ext;
      #2;
      chk("addr", file_addr, ea(r.op, r.ext));
      chk("idx", indexed_mode, !r.op[8] && r.ext && r.op[7:0] <= 8'h5f);
      d = r.val - 8'h01;
      if (!r.op[9]) w_e = d;
      st_e = {d[7], r.val == 8'h80, d == 8'h00, r.val[3:0] != 4'h0, r.val != 8'h00};
      run(r.op, r.val);
      chk("we", file_we, r.op[9]);
      if (r.op[9]) chk("wdata", file_wdata, d);
      if (r.op[9]) chk("waddr", file_waddr, ea(r.op, r.ext));
      chk("w", w_out, w_e);
      chk("st", status_out, st_e);
      chk("done", exec_done, 1'b1);
    end
    foreach (adj_rows[i]) begin
      a = adj_rows[i];
      load(a[9:2], {3'b101, a[1:0]});
      run(16'h0007, 8'h00);
      x = adj(a[9:2], a[1], a[0]);
      chk("w_adj", w_out, x[7:0]);
      chk("st_adj", status_out, {3'b101, a[1], x[8]});
      chk("done_adj", exec_done, 1'b1);
      chk("we_adj", file_we, 1'b0);
    end
    // unknown word: nothing changes, no completion
    run(16'h0008, 8'h00);
    chk("done_unk", exec_done, 1'b0);
    chk("w_unk", w_out, x[7:0]);
    // load beats a simultaneous adjust
    @(negedge clk);
    load_en = 1'b1;
    load_w = 8'h9a;
    load_status = 5'h00;
    instr_valid = 1'b1;
    instr = 16'h0007;
    @(negedge clk);
    load_en = 1'b0;
    instr_valid = 1'b0;
    chk("w_load", w_out, 16'h009a);
    chk("done_load", exec_done, 1'b0);
    // second reset in mid-run
    arst_n = 1'b0;
    #2;
    chk("w_rst2", w_out, 16'h0000);
    chk("st_rst2", status_out, 16'h0000);
    chk("done_rst2", exec_done, 16'h0000);
    @(negedge clk);
    arst_n = 1'b1;
    // first op right after release must still execute
    run(16'h0403, 8'h02);
    chk("w_post", w_out, 16'h0001);
    chk("st_post", status_out, 16'h0003);
    chk("done_post", exec_done, 1'b1);
    end_of_test();
  end
endmodule
